//--- hw/tfws_defs.vh
`ifndef TFWS_DEFS_VH
`define TFWS_DEFS_VH

// word indices; the bus byte address is four times the index
`define TFWS_IDX_BANDGAP 14'h2082
`define TFWS_IDX_OVERTEMP 14'h2083
`define TFWS_IDX_TEMP 14'h2084
`define TFWS_IDX_OSC 14'h2085
`define TFWS_IDX_CSOFF 14'h2086
`define TFWS_IDX_VAOFF 14'h2087
`define TFWS_IDX_SPANGAIN 14'h2088
`define TFWS_IDX_CTRL 14'h2090
`define TFWS_IDX_STATUS 14'h2091

// slot numbers of the stored words
`define TFWS_SLOT_BANDGAP 3'h0
`define TFWS_SLOT_OVERTEMP 3'h1
`define TFWS_SLOT_TEMP 3'h2
`define TFWS_SLOT_OSC 3'h3
`define TFWS_SLOT_CSOFF 3'h4
`define TFWS_SLOT_VAOFF 3'h5
`define TFWS_SLOT_SPANGAIN 3'h6
`define TFWS_SLOT_NONE 3'h7
`define TFWS_NUM_WORDS 7

// implemented bits of each word; erased value is all implemented ones
`define TFWS_MASK_BANDGAP 14'h001F
`define TFWS_MASK_OVERTEMP 14'h000F
`define TFWS_MASK_TEMP 14'h03FF
`define TFWS_MASK_OSC 14'h007F
`define TFWS_MASK_CSOFF 14'h007F
`define TFWS_MASK_VAOFF 14'h007F
`define TFWS_MASK_SPANGAIN 14'h1F0F

// field positions
`define TFWS_BANDGAP_LSB 0
`define TFWS_BANDGAP_MSB 4
`define TFWS_OVERTEMP_MSB 3
`define TFWS_TEMP_MSB 9
`define TFWS_SEVEN_MSB 6
`define TFWS_GAIN_MSB 3
`define TFWS_SPAN_LSB 8
`define TFWS_SPAN_MSB 12

// control and status fields
`define TFWS_CTRL_LOCK_BIT 0
`define TFWS_STAT_LOCK_BIT 8
`define TFWS_CTRL_RESET 1'b0

`endif

//--- hw/tfws_top.v
// Summary of operation
// - bandgap word: five-bit trim, upper bits zero
// - 2083h: overtemp trim bits 3-0, rest zero
// - 2084h: ten-bit temperature reading bits 9-0
// - temperature word bits 13-10 read zero
// - 2085h: oscillator trim bits 6-0, rest zero
// - 2086h: current sense offset trim bits 6-0
// - 2087h: voltage amp offset bits 6-0
// - 2088h: span 12-8, gain 3-0, rest zero
//
// Implementation choice: register access over Wishbone.
`timescale 1ns/1ns
`default_nettype none
`include "tfws_defs.vh"
module tfws_top (
	// clock, reset, enable
	input wire MCLK_I,
	input wire RST_N_I,
	input wire CE_I,
	// wishbone slave
	input wire WB_CYC_I,
	input wire WB_STB_I,
	input wire WB_WE_I,
	input wire [15:0] WB_ADR_I,
	input wire [3:0] WB_SEL_I,
	input wire [31:0] WB_DAT_I,
	output wire [31:0] WB_DAT_O,
	output wire WB_ACK_O,
	// factory programming port
	input wire PROG_WE_I,
	input wire [2:0] PROG_IDX_I,
	input wire [13:0] PROG_DATA_I,
	// status
	output wire PROG_LOCKED_O
);

////////////////////////////////////////////////////////////////////////////
// decode helpers

function [13:0] word_mask;
	input integer slot;
	begin
		case (slot)
			0: word_mask = `TFWS_MASK_BANDGAP;
			1: word_mask = `TFWS_MASK_OVERTEMP;
			2: word_mask = `TFWS_MASK_TEMP;
			3: word_mask = `TFWS_MASK_OSC;
			4: word_mask = `TFWS_MASK_CSOFF;
			5: word_mask = `TFWS_MASK_VAOFF;
			6: word_mask = `TFWS_MASK_SPANGAIN;
			default: word_mask = 14'h0000;
		endcase
	end
endfunction

// maps a word index to its slot
function [2:0] slot_of;
	input [13:0] idx;
	begin
		case (idx)
			`TFWS_IDX_BANDGAP: slot_of = `TFWS_SLOT_BANDGAP;
			`TFWS_IDX_OVERTEMP: slot_of = `TFWS_SLOT_OVERTEMP;
			`TFWS_IDX_TEMP: slot_of = `TFWS_SLOT_TEMP;
			`TFWS_IDX_OSC: slot_of = `TFWS_SLOT_OSC;
			`TFWS_IDX_CSOFF: slot_of = `TFWS_SLOT_CSOFF;
			`TFWS_IDX_VAOFF: slot_of = `TFWS_SLOT_VAOFF;
			`TFWS_IDX_SPANGAIN: slot_of = `TFWS_SLOT_SPANGAIN;
			default: slot_of = `TFWS_SLOT_NONE;
		endcase
	end
endfunction

////////////////////////////////////////////////////////////////////////////
// word storage

wire [14*`TFWS_NUM_WORDS-1:0] words_w;
wire [`TFWS_NUM_WORDS-1:0] programmed_w;
reg lock_r;
reg lock_nxt;

genvar gi;
generate
	for (gi = 0; gi < `TFWS_NUM_WORDS; gi = gi + 1) begin : g_word
		tfws_word #(
			.MASK(word_mask(gi))
		) u_word (
			.clk_i(MCLK_I),
			.rst_n_i(RST_N_I),
			.ce_i(CE_I),
			// once locked, the factory port is dead until reset
			.load_i(PROG_WE_I && !lock_r && (PROG_IDX_I == gi)),
			.data_i(PROG_DATA_I),
			.word_o(words_w[14*gi +: 14]),
			.programmed_o(programmed_w[gi])
		);
	end
endgenerate

////////////////////////////////////////////////////////////////////////////
// wishbone slave

reg ack_r;
reg ack_nxt;
reg [31:0] dat_r;
reg [31:0] dat_nxt;
wire [13:0] idx_w;
wire [2:0] slot_w;
wire req_w;

assign idx_w = WB_ADR_I[15:2];
assign slot_w = slot_of(idx_w);
assign req_w = WB_CYC_I && WB_STB_I && !ack_r;

always @* begin
	ack_nxt = req_w;
	dat_nxt = dat_r;
	lock_nxt = lock_r;
	if (req_w) begin
		dat_nxt = 32'h00000000;
		if (slot_w != `TFWS_SLOT_NONE) begin
			// writes are acked but dropped
			dat_nxt = {18'h00000, words_w[14*slot_w +: 14]};
		end else if (idx_w == `TFWS_IDX_CTRL) begin
			dat_nxt = {31'h00000000, lock_r};
		end else if (idx_w == `TFWS_IDX_STATUS) begin
			dat_nxt = {23'h000000, lock_r, 1'b0, programmed_w};
		end
		// lock is write-once: only a reset reopens programming
		if (WB_WE_I && WB_SEL_I[0] && idx_w == `TFWS_IDX_CTRL &&
			WB_DAT_I[`TFWS_CTRL_LOCK_BIT]) begin
			lock_nxt = 1'b1;
		end
		if (WB_WE_I) begin
			dat_nxt = 32'h00000000;
		end
	end
end

always @(posedge MCLK_I or negedge RST_N_I) begin
	if (!RST_N_I) begin
		ack_r <= 1'b0;
		dat_r <= 32'h00000000;
		lock_r <= `TFWS_CTRL_RESET;
	end else if (CE_I) begin
		ack_r <= ack_nxt;
		dat_r <= dat_nxt;
		lock_r <= lock_nxt;
	end
end

assign WB_ACK_O = ack_r;
assign WB_DAT_O = dat_r;
assign PROG_LOCKED_O = lock_r;

endmodule
`default_nettype wire

//--- hw/tfws_word.v
`timescale 1ns/1ns
`default_nettype none
// one factory trim word; only the factory load port and reset can change it
module tfws_word #(
	parameter [13:0] MASK = 14'h3FFF
) (
	// clock and reset
	input wire clk_i,
	input wire rst_n_i,
	input wire ce_i,
	// factory load
	input wire load_i,
	input wire [13:0] data_i,
	// stored value
	output wire [13:0] word_o,
	output wire programmed_o
);

reg [13:0] word_r;
reg programmed_r;

always @(posedge clk_i or negedge rst_n_i) begin
	if (!rst_n_i) begin
		// erased cells read as ones in the implemented bits
		word_r <= MASK;
		programmed_r <= 1'b0;
	end else if (ce_i && load_i) begin
		// unimplemented bits are never stored, so they read zero
		word_r <= data_i & MASK;
		programmed_r <= 1'b1;
	end
end

assign word_o = word_r;
assign programmed_o = programmed_r;

endmodule
`default_nettype wire

//--- tb/factory_trim_word_store_bench.sv
`timescale 1ns/1ns
`default_nettype none
module factory_trim_word_store_bench;
	logic mclk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0, pwe = 0;
	logic [15:0] adr = 16'h0;
	logic [31:0] dat = 32'h0, q, dato;
	logic ack, lkd;
	logic [2:0] pidx = 3'h0;
	logic [13:0] pd = 14'h0;
	int fails = 0, n_tests = 0;
	// implemented bits per slot, bandgap first
	logic [13:0] msk [7] = '{14'h001F, 14'h000F, 14'h03FF, 14'h007F,
		14'h007F, 14'h007F, 14'h1F0F};
	always #50 mclk = ~mclk;
	tfws_top dut_u (.MCLK_I(mclk), .RST_N_I(rst_n), .CE_I(1'b1),
		.WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
		.WB_SEL_I(4'hF), .WB_DAT_I(dat), .WB_DAT_O(dato), .WB_ACK_O(ack),
		.PROG_WE_I(pwe), .PROG_IDX_I(pidx), .PROG_DATA_I(pd),
		.PROG_LOCKED_O(lkd));
	// no bound here: the watchdog ends a hung cycle
	task wb(input logic w, input logic [15:0] a, input logic [31:0] d);
		cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d;
		do @(posedge mclk); while (ack !== 1'b1);
		q = dato;
		cyc <= 1'b0; stb <= 1'b0;
		@(posedge mclk);
	endtask
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			fails++;
			$display("[ERR] %s exp %h got %h", nm, e, g);
		end
	endtask
	task summarize;
		if (fails == 0 && n_tests > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task t_erased;
		for (int s = 0; s < 7; s++) begin
			wb(1'b0, 16'h8208 + 16'(4 * s), 32'h0);
			chk("erased", {18'h0, msk[s]}, q);
		end
	endtask
	task t_prog(input logic [13:0] v);
		for (int s = 0; s < 7; s++) begin
			pwe <= 1'b1; pidx <= 3'(s); pd <= v;
			@(posedge mclk);
			pwe <= 1'b0;
			wb(1'b0, 16'h8208 + 16'(4 * s), 32'h0);
			chk("loaded", {18'h0, v & msk[s]}, q);
		end
	endtask
	task t_wr(input logic [13:0] v);
		for (int s = 0; s < 7; s++) begin
			wb(1'b1, 16'h8208 + 16'(4 * s), 32'hFFFFFFFF);
			wb(1'b0, 16'h8208 + 16'(4 * s), 32'h0);
			chk("kept", {18'h0, v & msk[s]}, q);
		end
		wb(1'b0, 16'h0000, 32'h0);
		chk("unmapped", 32'h0, q);
	endtask
	// firmware view: each field except bandgap and temperature pulled out of its word after t_prog(1555)
	task t_fw;
		wb(1'b0, 16'h820C, 32'h0);
		chk("overtemp field", 32'h5, {28'h0, q[3:0]});
		wb(1'b0, 16'h8214, 32'h0);
		chk("osc field", 32'h55, {25'h0, q[6:0]});
		wb(1'b0, 16'h8218, 32'h0);
		chk("sense offset field", 32'h55, {25'h0, q[6:0]});
		wb(1'b0, 16'h821C, 32'h0);
		chk("vamp offset field", 32'h55, {25'h0, q[6:0]});
		wb(1'b0, 16'h8220, 32'h0);
		chk("span field", 32'h15, {27'h0, q[12:8]});
		chk("gain field", 32'h5, {28'h0, q[3:0]});
	endtask
	// lock closes the factory port until reset
	task t_lock;
		chk("lock before", 32'h0, {31'h0, lkd});
		wb(1'b0, 16'h8244, 32'h0);
		chk("status", 32'h0000007F, q);
		wb(1'b1, 16'h8240, 32'h1);
		chk("write data", 32'h0, q);
		chk("lock pin", 32'h1, {31'h0, lkd});
		wb(1'b0, 16'h8240, 32'h0);
		chk("control", 32'h1, q);
		wb(1'b0, 16'h8244, 32'h0);
		chk("status locked", 32'h0000017F, q);
		pwe <= 1'b1; pidx <= 3'h0; pd <= 14'h0AAA;
		@(posedge mclk);
		pwe <= 1'b0;
		wb(1'b0, 16'h8208, 32'h0);
		chk("locked load", 32'h15, q);
	endtask
	initial begin
		repeat (6) @(posedge mclk);
		rst_n <= 1'b1;
		t_erased;
		t_prog(14'h2AAA);
		t_prog(14'h1555);
		t_fw;
		t_wr(14'h1555);
		t_lock;
		summarize;
	end
	initial begin
		#200000;
		fails++;
		summarize;
	end
endmodule
`default_nettype wire

//--- tb/tfws_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module tfws_chk (
	input wire logic MCLK_I, RST_N_I, CE_I, WB_CYC_I, WB_STB_I, WB_WE_I,
	input wire logic [15:0] WB_ADR_I,
	input wire logic [31:0] WB_DAT_O,
	input wire logic WB_ACK_O
);
	default clocking @(posedge MCLK_I); endclocking
	default disable iff (!RST_N_I);
	wire logic rd = WB_ACK_O && !WB_WE_I;
	wire logic [13:0] ix = WB_ADR_I[15:2];
	sequence s_req;
		WB_CYC_I && WB_STB_I && !WB_ACK_O && CE_I;
	endsequence
	property p_ack; s_req |=> WB_ACK_O ##1 !WB_ACK_O; endproperty
	a_ack: assert property (p_ack) else $error("ack not one pulse");
	property p_bg; rd && ix == 14'h2082 |-> WB_DAT_O[31:5] == 27'h0; endproperty
	a_bg: assert property (p_bg) else $error("bandgap high bits");
	property p_ot; rd && ix == 14'h2083 |-> WB_DAT_O[31:4] == 28'h0; endproperty
	a_ot: assert property (p_ot) else $error("overtemp high bits");
	property p_tp; rd && ix == 14'h2084 |-> WB_DAT_O[31:10] == 22'h0; endproperty
	a_tp: assert property (p_tp) else $error("temp high bits");
	property p_os; rd && ix == 14'h2085 |-> WB_DAT_O[31:7] == 25'h0; endproperty
	a_os: assert property (p_os) else $error("osc high bits");
	property p_cs; rd && ix == 14'h2086 |-> WB_DAT_O[31:7] == 25'h0; endproperty
	a_cs: assert property (p_cs) else $error("sense high bits");
	property p_va; rd && ix == 14'h2087 |-> WB_DAT_O[31:7] == 25'h0; endproperty
	a_va: assert property (p_va) else $error("vamp high bits");
	property p_sg;
		rd && ix == 14'h2088 |-> !(|WB_DAT_O[31:13]) && !(|WB_DAT_O[7:4]);
	endproperty
	a_sg: assert property (p_sg) else $error("span gain gap bits");
endmodule
bind tfws_top tfws_chk chk_u (.MCLK_I, .RST_N_I, .CE_I, .WB_CYC_I, .WB_STB_I,
	.WB_WE_I, .WB_ADR_I, .WB_DAT_O, .WB_ACK_O);
`default_nettype wire
